// ===== hdl/msq_ctrl.sv
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// What this block and its host must do
// [RULE1] deserialise words, route payload by index
// [RULE2] score entries wait in 32-word buffer
// [RULE3] request when level at or below threshold
// [RULE4] start command begins fetching entries in order
// [RULE5] each processed entry leaves the buffer
// [RULE6] eight timbres stored at indices 10h-2Fh
// [RULE7] hardware reset clears timbre storage
// [RULE8] soft wipe keeps timbre storage
// [RULE9] power-down keeps timbre storage
// [RULE10] four voices, each with own timbre
// [RULE11] accept run, stop and tempo settings
// [RULE12] host powers up, loads timbres, score, starts
// [RULE13] host refills before buffer runs empty
// [RULE14] host loads timbres before sound starts
// [RULE15] words arrive on data, bit clock, strobe
// [RULE16] index 00h appends one score entry
// [RULE17] unused bits zero, ones are ignored
// [RULE18] host never touches reserved or test indices
// [RULE19] frame: index then 16 bits, msb first
// [RULE20] request low while at or below threshold
module msq_ctrl #(
  parameter int TEMPO_STEP_CYCLES = msq_pkg::TEMPO_STEP_CYC
) (
  // clock and reset
  input logic clk,
  input logic rst,
  // serial control link pins
  input logic serialFrameSync,
  input logic serialBitClk,
  input logic serial_word_in,
  // refill request to the host, active low
  output logic refillReqN,
  // voice control towards the synthesizer
  output logic [msq_pkg::VOICES-1:0] voiceKeyOn,
  output logic [msq_pkg::VOICES*6-1:0] voicePitch,
  output logic [msq_pkg::VOICES-1:0] voiceVibrato,
  output logic [msq_pkg::VOICES*3-1:0] voiceTimbre,
  output logic powerDown,
  // axi4-lite write channels
  input logic [11:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  // axi4-lite read channels
  input logic [11:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready
);
  import msq_pkg::*;

  typedef struct packed {
    logic [TIMBRE_WORDS-1:0][WORD_W-1:0] timbre;
    logic [11:0] allot;
    logic [7:0] tempo;
    logic run;
    logic pd;
    logic reqEn;
    logic [4:0] reqPoint;
    logic linkEn;
    logic [15:0] wordCount;
    msq_seq_t seqState;
    logic [31:0] holdCnt;
    logic [VOICES-1:0] keyOn;
    logic [VOICES*6-1:0] pitch;
    logic [VOICES-1:0] vib;
    logic reqN;
    logic awHave;
    logic [11:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } msq_state_t;

  msq_state_t s_reg;
  msq_state_t s_next;

  // link receiver outputs
  logic rxValid;
  logic [IDX_W-1:0] rxIndex;
  logic [WORD_W-1:0] rxData;
  // score buffer wires
  logic fifoPush;
  logic fifoPop;
  logic fifoEmpty;
  logic fifoFull;
  logic [WORD_W-1:0] fifoHead;
  logic [FIFO_AW:0] fifoLevel;
  // decoded link actions
  logic linkWord;
  logic timbreWr;
  logic [4:0] timbreSlot;
  logic softWipe;
  logic seqHalt;
  logic reqCond;
  // bus helpers
  logic awFire;
  logic wFire;
  logic arFire;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  msq_reg_t wrTarget;
  msq_reg_t rdTarget;

  // maps a byte address to the register it selects; shared by both bus paths
  function automatic msq_reg_t regOf(input logic [11:0] addr);
    if (addr == OFS_STATUS) begin
      return REG_STATUS;
    end else if (addr == OFS_LINK_CTRL) begin
      return REG_LINK;
    end else if (addr == OFS_WORD_COUNT) begin
      return REG_COUNT;
    end else if (addr == OFS_SEQ_VIEW) begin
      return REG_VIEW;
    end else if (addr[11:7] == OFS_TIMBRE[11:7] && addr[1:0] == 2'h0) begin
      return REG_TIMBRE;
    end else begin
      return REG_NONE;
    end
  endfunction

  msq_serial_rx u_rx (
    .clk(clk),
    .rst(rst),
    .frameSyncPin(serialFrameSync),
    .bitClkPin(serialBitClk),
    .dataPin(serial_word_in),
    .wordValid(rxValid),
    .wordIndex(rxIndex),
    .wordData(rxData)
  );

  msq_score_fifo u_fifo (
    .clk(clk),
    .rst(rst),
    .clear(softWipe),
    .push(fifoPush),
    .pushData(rxData),
    .pop(fifoPop),
    .headData(fifoHead),
    .level(fifoLevel),
    .empty(fifoEmpty),
    .full(fifoFull)
  );

  // link word decode; words are dropped while software holds the link off
  assign linkWord = rxValid && s_reg.linkEn;
  assign fifoPush = linkWord && (rxIndex == IDX_SCORE); // RULE16
  assign timbreWr = linkWord && (rxIndex >= IDX_TIMBRE_LO) && (rxIndex <= IDX_TIMBRE_HI); // RULE6
  assign timbreSlot = 5'(rxIndex - IDX_TIMBRE_LO);
  assign softWipe = linkWord && (rxIndex == IDX_FM_CTRL) && rxData[SOFT_WIPE_BIT]; // RULE8
  // a wipe in flight halts at once so no stale entry gets fetched
  assign seqHalt = !s_reg.run || s_reg.pd || softWipe;
  assign fifoPop = (s_reg.seqState == SEQ_FETCH) && !seqHalt; // RULE5
  assign reqCond = s_reg.reqEn && (fifoLevel <= {1'b0, s_reg.reqPoint}); // RULE3

  // bus handshakes and the write that results from them
  assign awFire = awvalid && s_reg.awReady;
  assign wFire = wvalid && s_reg.wReady;
  assign arFire = arvalid && s_reg.arReady;
  assign wrAddr = s_reg.awHave ? s_reg.awAddr : awaddr;
  assign wrData = s_reg.wHave ? s_reg.wData : wdata;
  assign wrStrb = s_reg.wHave ? s_reg.wStrb : wstrb;
  assign wrTarget = regOf(wrAddr);
  assign rdTarget = regOf(araddr);

  // one process computes every next value of the block
  always_comb begin
    s_next = s_reg;
    // route each received word by its index
    if (linkWord) begin // RULE1
      s_next.wordCount = s_reg.wordCount + 16'h0001;
      if (timbreWr) begin
        s_next.timbre[timbreSlot] = rxData; // RULE6
      end else if (rxIndex == IDX_ALLOT) begin
        s_next.allot = {rxData[14:12], rxData[10:8], rxData[6:4], rxData[2:0]}; // RULE17
      end else if (rxIndex == IDX_TEMPO) begin
        s_next.tempo = rxData[7:0]; // RULE11
      end else if (rxIndex == IDX_FM_CTRL) begin
        s_next.run = rxData[SEQUENCE_RUN_BIT] && !rxData[SOFT_WIPE_BIT]; // RULE11
      end else if (rxIndex == IDX_REQ_CTRL) begin
        s_next.reqEn = rxData[REQ_EN_BIT];
        s_next.reqPoint = rxData[4:0];
      end else if (rxIndex == IDX_POWER) begin
        s_next.pd = rxData[POWER_DOWN_BIT]; // RULE9
      end
      // other indices, reserved and test space included, are ignored // RULE18
    end

    // sequencer: silence on stop, wipe or power-down, else walk the buffer
    if (seqHalt) begin
      s_next.seqState = SEQ_IDLE;
      s_next.keyOn = '0; // RULE11
      s_next.holdCnt = '0;
    end else begin
      case (s_reg.seqState)
        SEQ_IDLE: begin
          if (!fifoEmpty) begin
            s_next.seqState = SEQ_FETCH; // RULE4
          end
        end
        SEQ_FETCH: begin
          // head entry goes to the voice named by its channel field
          if (fifoHead[15:14] == 2'h0) begin
            s_next.keyOn[fifoHead[CHAN_POS +: 2]] = 1'b0; // rest entry
          end else begin
            s_next.keyOn[fifoHead[CHAN_POS +: 2]] = 1'b1; // RULE10
            s_next.pitch[6 * fifoHead[CHAN_POS +: 2] +: 6] = fifoHead[PITCH_POS +: 6];
            s_next.vib[fifoHead[CHAN_POS +: 2]] = fifoHead[VIB_POS];
          end
          s_next.holdCnt = 32'((32'(s_reg.tempo) + 32'h1) * TEMPO_STEP_CYCLES - 32'h1);
          s_next.seqState = SEQ_HOLD;
        end
        SEQ_HOLD: begin
          if (s_reg.holdCnt != 32'h0) begin
            s_next.holdCnt = s_reg.holdCnt - 32'h1;
          end else if (!fifoEmpty) begin
            s_next.seqState = SEQ_FETCH; // RULE4
          end else begin
            s_next.seqState = SEQ_IDLE; // underrun: last notes keep sounding
          end
        end
        default: begin
          s_next.seqState = SEQ_IDLE;
        end
      endcase
    end

    // refill request follows the buffer level, one cycle late
    s_next.reqN = !reqCond; // RULE20

    // bus write: address and data taken in either order
    if (awFire) begin
      s_next.awHave = 1'b1;
      s_next.awAddr = awaddr;
    end
    if (wFire) begin
      s_next.wHave = 1'b1;
      s_next.wData = wdata;
      s_next.wStrb = wstrb;
    end
    if ((s_reg.awHave || awFire) && (s_reg.wHave || wFire)) begin
      s_next.awHave = 1'b0;
      s_next.wHave = 1'b0;
      s_next.bValid = 1'b1;
      s_next.bResp = (wrTarget == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (wrTarget == REG_LINK && wrStrb[0]) begin
        s_next.linkEn = wrData[0];
      end
    end else if (s_reg.bValid && bready) begin
      s_next.bValid = 1'b0;
    end
    // only one write is ever under way
    s_next.awReady = !s_next.awHave && !s_next.bValid;
    s_next.wReady = !s_next.wHave && !s_next.bValid;

    // bus read: answer in the cycle after the address is taken
    if (arFire) begin
      s_next.rValid = 1'b1;
      s_next.rResp = RESP_OKAY;
      s_next.rData = 32'h0;
      if (rdTarget == REG_STATUS) begin
        s_next.rData = {21'h0, !s_reg.reqN, s_reg.pd, s_reg.run, s_reg.seqState != SEQ_IDLE, 1'b0, fifoLevel};
      end else if (rdTarget == REG_LINK) begin
        s_next.rData = {31'h0, s_reg.linkEn};
      end else if (rdTarget == REG_COUNT) begin
        s_next.rData = {16'h0, s_reg.wordCount};
      end else if (rdTarget == REG_VIEW) begin
        s_next.rData = {s_reg.allot, s_reg.reqEn, s_reg.reqPoint, s_reg.run, s_reg.tempo, 5'h0};
      end else if (rdTarget == REG_TIMBRE) begin
        s_next.rData = {16'h0, s_reg.timbre[araddr[6:2]]};
      end else begin
        s_next.rResp = RESP_SLVERR;
      end
    end else if (s_reg.rValid && rready) begin
      s_next.rValid = 1'b0;
    end
    s_next.arReady = !s_next.rValid;
  end

  // timbre storage is cleared here and nowhere else
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0; // RULE7
      s_reg.tempo <= TEMPO_RST;
      s_reg.reqPoint <= REQ_POINT_RST;
      s_reg.linkEn <= LINK_EN_RST;
      s_reg.reqN <= 1'b1;
      s_reg.awReady <= 1'b1;
      s_reg.wReady <= 1'b1;
      s_reg.arReady <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // every output comes straight from the state flops
  assign refillReqN = s_reg.reqN;
  assign voiceKeyOn = s_reg.keyOn;
  assign voicePitch = s_reg.pitch;
  assign voiceVibrato = s_reg.vib;
  assign voiceTimbre = s_reg.allot; // RULE10
  assign powerDown = s_reg.pd;
  assign awready = s_reg.awReady;
  assign wready = s_reg.wReady;
  assign bresp = s_reg.bResp;
  assign bvalid = s_reg.bValid;
  assign arready = s_reg.arReady;
  assign rdata = s_reg.rData;
  assign rresp = s_reg.rResp;
  assign rvalid = s_reg.rValid;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_req_follows_level: assert property (1'b1 |=> refillReqN == !$past(reqCond)) // RULE3
    else $error("refill request does not track buffer level");
  a_start_fetch: assert property (s_reg.seqState == SEQ_IDLE && !seqHalt && !fifoEmpty
      |=> s_reg.seqState == SEQ_FETCH) // RULE4
    else $error("started sequencer did not fetch");
  a_fetch_pops: assert property (s_reg.seqState == SEQ_FETCH && !seqHalt |-> fifoPop ##1 s_reg.seqState == SEQ_HOLD) // RULE5
    else $error("fetched entry not removed");
  a_timbre_route: assert property (timbreWr |=> s_reg.timbre[$past(timbreSlot)] == $past(rxData)) // RULE6
    else $error("timbre word not stored at its slot");
  a_wipe_keeps_timbre: assert property (softWipe |=> $stable(s_reg.timbre)) // RULE8
    else $error("soft wipe disturbed timbre storage");
  a_pd_keeps_timbre: assert property (s_reg.pd && !timbreWr |=> $stable(s_reg.timbre)) // RULE9
    else $error("power-down disturbed timbre storage");
  a_stop_silences: assert property (!s_reg.run |=> voiceKeyOn == '0 && s_reg.seqState == SEQ_IDLE) // RULE11
    else $error("stopped sequencer still sounding");
  a_wipe_empties: assert property (softWipe |=> fifoEmpty ##1 voiceKeyOn == '0) // RULE8
    else $error("soft wipe left entries or voices");
  a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
endmodule // msq_ctrl

// ===== hdl/msq_pkg.sv
package msq_pkg;
  // clock and tempo step timing
  localparam int CLK_HZ = 10_000_000;
  localparam int TEMPO_STEP_NS = 100_000;
  localparam int TEMPO_STEP_CYC = TEMPO_STEP_NS / (1_000_000_000 / CLK_HZ);
  // serial frame and word sizes
  localparam int IDX_W = 8;
  localparam int WORD_W = 16;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
  // score buffer
  localparam int FIFO_AW = 5;
  localparam int FIFO_DEPTH = 32;
  localparam logic [5:0] FIFO_FULL_LVL = 6'h20;
  // link word indices
  localparam logic [7:0] IDX_SCORE = 8'h00;
  localparam logic [7:0] IDX_TIMBRE_LO = 8'h10;
  localparam logic [7:0] IDX_TIMBRE_HI = 8'h2f;
  localparam logic [7:0] IDX_ALLOT = 8'h30;
  localparam logic [7:0] IDX_TEMPO = 8'h31;
  localparam logic [7:0] IDX_FM_CTRL = 8'h32;
  localparam logic [7:0] IDX_REQ_CTRL = 8'h34;
  localparam logic [7:0] IDX_POWER = 8'h38;
  // field positions within link words
  localparam int SEQUENCE_RUN_BIT = 0;
  localparam int SOFT_WIPE_BIT = 1;
  localparam int REQ_EN_BIT = 5;
  localparam int POWER_DOWN_BIT = 0;
  localparam int PITCH_POS = 10;
  localparam int CHAN_POS = 8;
  localparam int VIB_POS = 7;
  // voices and timbre words
  localparam int VOICES = 4;
  localparam int TIMBRE_WORDS = 32;
  // reset values
  localparam logic [7:0] TEMPO_RST = 8'h00;
  localparam logic [4:0] REQ_POINT_RST = 5'h00;
  localparam logic LINK_EN_RST = 1'b1;
  // bus offsets and answers
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_LINK_CTRL = 12'h004;
  localparam logic [11:0] OFS_WORD_COUNT = 12'h008;
  localparam logic [11:0] OFS_SEQ_VIEW = 12'h00c;
  localparam logic [11:0] OFS_TIMBRE = 12'h100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer states and decoded bus targets
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FETCH, SEQ_HOLD} msq_seq_t;
  typedef enum logic [2:0] {REG_NONE, REG_STATUS, REG_LINK, REG_COUNT, REG_VIEW, REG_TIMBRE} msq_reg_t;
endpackage

// ===== hdl/msq_score_fifo.sv
`timescale 1ns/1ps
module msq_score_fifo (
  // clock and reset
  input logic clk,
  input logic rst,
  input logic clear,
  // fill side
  input logic push,
  input logic [msq_pkg::WORD_W-1:0] pushData,
  // drain side
  input logic pop,
  output logic [msq_pkg::WORD_W-1:0] headData,
  // fill state
  output logic [msq_pkg::FIFO_AW:0] level,
  output logic empty,
  output logic full
);
  import msq_pkg::*;

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][WORD_W-1:0] mem;
    logic [FIFO_AW-1:0] wrPtr;
    logic [FIFO_AW-1:0] rdPtr;
    logic [FIFO_AW:0] level;
  } msq_fifo_t;

  msq_fifo_t s_reg;
  msq_fifo_t s_next;
  logic doPush;
  logic doPop;

  // a push into a full buffer is dropped; the refill request exists to avoid it
  always_comb begin
    s_next = s_reg;
    doPush = push && (s_reg.level != FIFO_FULL_LVL);
    doPop = pop && (s_reg.level != 6'h00);
    if (clear) begin
      s_next.wrPtr = '0;
      s_next.rdPtr = '0;
      s_next.level = '0;
    end else begin
      if (doPush) begin
        s_next.mem[s_reg.wrPtr] = pushData; // RULE2
        s_next.wrPtr = s_reg.wrPtr + 5'h01;
      end
      if (doPop) begin
        s_next.rdPtr = s_reg.rdPtr + 5'h01; // RULE5
      end
      if (doPush && !doPop) begin
        s_next.level = s_reg.level + 6'h01;
      end else if (doPop && !doPush) begin
        s_next.level = s_reg.level - 6'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign headData = s_reg.mem[s_reg.rdPtr];
  assign level = s_reg.level;
  assign empty = (s_reg.level == 6'h00);
  assign full = (s_reg.level == FIFO_FULL_LVL);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_fifo_cap: assert property (level <= FIFO_FULL_LVL) // RULE2
    else $error("score buffer level beyond capacity");
  a_fifo_push: assert property (push && !pop && !full && !clear |=> level == $past(level) + 6'h01) // RULE16
    else $error("push did not add one entry");
  a_fifo_pop: assert property (pop && !push && !empty && !clear |=> level == $past(level) - 6'h01) // RULE5
    else $error("pop did not remove one entry");
endmodule // msq_score_fifo

// ===== hdl/msq_serial_rx.sv
`timescale 1ns/1ps
module msq_serial_rx (
  // clock and reset
  input logic clk,
  input logic rst,
  // link pins, asynchronous to clk
  input logic frameSyncPin,
  input logic bitClkPin,
  input logic dataPin,
  // received word
  output logic wordValid,
  output logic [msq_pkg::IDX_W-1:0] wordIndex,
  output logic [msq_pkg::WORD_W-1:0] wordData
);
  import msq_pkg::*;

  typedef struct packed {
    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    logic clkPrev;
    logic [22:0] shift;
    logic [4:0] bitCnt;
    logic valid;
    logic [IDX_W-1:0] idx;
    logic [WORD_W-1:0] data;
  } msq_rx_t;

  msq_rx_t s_reg;
  msq_rx_t s_next;

  // pins pass two flops; edges are found on the second stage only
  always_comb begin
    s_next = s_reg;
    s_next.pinMeta = {frameSyncPin, bitClkPin, dataPin};
    s_next.pinSync = s_reg.pinMeta;
    s_next.clkPrev = s_reg.pinSync[1];
    s_next.valid = 1'b0;
    if (!s_reg.pinSync[2]) begin
      s_next.bitCnt = 5'h00; // a dropped frame strobe discards a partial word
    end else if (s_reg.pinSync[1] && !s_reg.clkPrev) begin // RULE15
      if (s_reg.bitCnt == FRAME_LAST_BIT) begin
        s_next.valid = 1'b1; // RULE19
        {s_next.idx, s_next.data} = {s_reg.shift, s_reg.pinSync[0]};
        s_next.bitCnt = 5'h00;
      end else begin
        s_next.shift = {s_reg.shift[21:0], s_reg.pinSync[0]}; // msb first
        s_next.bitCnt = s_reg.bitCnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wordValid = s_reg.valid;
  assign wordIndex = s_reg.idx;
  assign wordData = s_reg.data;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_word_pulse: assert property (wordValid |=> !wordValid) // RULE19
    else $error("word strobe longer than one cycle");
endmodule // msq_serial_rx

// ===== sim/msq_ctrl_bench.sv
`timescale 1ns/1ps
module msq_ctrl_bench;
  import msq_pkg::*;
  localparam int STEP = 4;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic frameSync, bitClk, dataLine, refillReqN, powerDown;
  logic [3:0] voiceKeyOn, voiceVibrato;
  logic [23:0] voicePitch;
  logic [11:0] voiceTimbre;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int errCount = 0;
  int numChecks = 0;

  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  msq_link_host host (.frameSync(frameSync), .bitClk(bitClk), .dataLine(dataLine));

  msq_ctrl #(.TEMPO_STEP_CYCLES(STEP)) DUT (.clk(clk), .rst(rst), .serialFrameSync(frameSync),
    .serialBitClk(bitClk), .serial_word_in(dataLine), .refillReqN(refillReqN), .voiceKeyOn(voiceKeyOn),
    .voicePitch(voicePitch), .voiceVibrato(voiceVibrato), .voiceTimbre(voiceTimbre), .powerDown(powerDown),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // comparisons
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    chkVal({30'h0, got}, {30'h0, exp});
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] expResp);
    logic aTake, wTake;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(negedge clk);
      aTake = awready & awvalid;
      wTake = wready & wvalid;
      @(posedge clk);
      if (aTake) awvalid <= 1'h0;
      if (wTake) wvalid <= 1'h0;
    end while (awvalid || wvalid);
    bready <= 1'h1;
    do @(negedge clk); while (bvalid !== 1'h1);
    chkResp(bresp, expResp);
    @(posedge clk);
    bready <= 1'h0;
  endtask

  // read: ready sampled at the falling edge, so the take happens at the next rise
  task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    do @(negedge clk); while (arready !== 1'h1);
    @(posedge clk);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do @(negedge clk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'h0;
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    axiRd(a, rd, rs);
    chkResp(rs, RESP_OKAY);
    chkVal(rd & m, e);
  endtask

  // only indices below 40h are ever sent; ends on a falling edge so outputs are settled
  task automatic link(input logic [7:0] idx, input logic [15:0] d, input int n = 24);
    host.sendWord(idx, d, n);
    repeat (12) @(negedge clk);
  endtask

  // reset values, unmapped and read-only register accesses
  task automatic tResetState();
    chkVal({10'h0, refillReqN, voiceKeyOn, voiceVibrato, powerDown, voiceTimbre}, 32'h00200000);
    rdChk(OFS_STATUS, 32'h0);
    rdChk(OFS_LINK_CTRL, 32'h1);
    rdChk(OFS_TIMBRE, 32'h0);
    axiRd(12'h200, rd, rs);
    chkResp(rs, RESP_SLVERR);
    chkVal(rd, 32'h0);
    axiWr(12'h010, 32'h1, RESP_SLVERR);
    axiWr(OFS_WORD_COUNT, 32'hffff, RESP_OKAY);
    rdChk(OFS_WORD_COUNT, 32'h0);
  endtask

  // routing by index; cut-short frames and a disabled link leave storage alone
  task automatic tTimbreRoute();
    link(IDX_POWER, 16'h0000);
    link(IDX_TIMBRE_LO, 16'ha5c3);
    link(IDX_TIMBRE_HI, 16'h5a3c);
    link(8'h11, 16'h7777, 23);
    rdChk(OFS_TIMBRE, 32'ha5c3);
    rdChk(OFS_TIMBRE + 12'h07c, 32'h5a3c);
    rdChk(OFS_TIMBRE + 12'h004, 32'h0);
    rdChk(OFS_WORD_COUNT, 32'h3);
    axiWr(OFS_LINK_CTRL, 32'h0, RESP_OKAY);
    link(8'h12, 16'h1234);
    rdChk(OFS_TIMBRE + 12'h008, 32'h0);
    axiWr(OFS_LINK_CTRL, 32'h1, RESP_OKAY);
  endtask

  // power-down and its release keep the stored timbres
  task automatic tPowerDown();
    link(IDX_POWER, 16'h0001);
    chkVal({31'h0, powerDown}, 32'h1);
    rdChk(OFS_STATUS, 32'h200, 32'h200);
    link(IDX_POWER, 16'h0000);
    chkVal({31'h0, powerDown}, 32'h0);
    rdChk(OFS_TIMBRE, 32'ha5c3);
  endtask

  // request tracks level against point 3; the 33rd entry is dropped
  task automatic tFill();
    link(IDX_REQ_CTRL, 16'h0023);
    chkVal({31'h0, refillReqN}, 32'h0);
    link(IDX_SCORE, 16'h5680);
    link(IDX_SCORE, 16'hc000);
    link(IDX_SCORE, 16'h0000);
    chkVal({31'h0, refillReqN}, 32'h0);
    link(IDX_SCORE, 16'h0000);
    chkVal({31'h0, refillReqN}, 32'h1);
    for (int i = 4; i < 33; i++) begin
      link(IDX_SCORE, 16'h0000);
    end
    rdChk(OFS_STATUS, 32'h20, 32'h7ff);
  endtask

  // playback with a long hold so each fetched entry can be seen
  task automatic tPlay();
    link(IDX_ALLOT, 16'h7531);
    link(IDX_TEMPO, 16'h7ff0);
    rdChk(OFS_SEQ_VIEW, 32'h8de00, 32'hfffe0);
    link(IDX_FM_CTRL, 16'h0001);
    chkVal({voiceKeyOn, voiceVibrato, voicePitch}, {4'h4, 4'h4, 24'h015000});
    chkVal({20'h0, voiceTimbre}, 32'hf59);
    rdChk(OFS_STATUS, 32'h19f, 32'h7ff);
    repeat (1000) @(negedge clk);
    chkVal({voiceKeyOn, voiceVibrato, voicePitch}, {4'h5, 4'h4, 24'h015030});
    rdChk(OFS_STATUS, 32'h19e, 32'h7ff);
  endtask

  // soft wipe empties and stops but keeps timbres
  task automatic tWipe();
    link(IDX_FM_CTRL, 16'h0002);
    chkVal({28'h0, voiceKeyOn}, 32'h0);
    rdChk(OFS_STATUS, 32'h400, 32'h7ff);
    rdChk(OFS_TIMBRE, 32'ha5c3);
    rdChk(OFS_TIMBRE + 12'h07c, 32'h5a3c);
    // host answers the raised request with fresh entries until it drops
    repeat (4) link(IDX_SCORE, 16'h0000);
    chkVal({31'h0, refillReqN}, 32'h1);
  endtask

  // hardware reset after the wipe, sequencer stopped: buffer and, unlike a soft wipe, timbres are cleared
  task automatic tHwReset();
    @(posedge clk);
    rst <= 1'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    rdChk(OFS_TIMBRE, 32'h0);
    rdChk(OFS_TIMBRE + 12'h07c, 32'h0);
    rdChk(OFS_STATUS, 32'h0);
  endtask

  // verdict and end of run
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk); // look at outputs only once they have settled
    tResetState();
    tTimbreRoute();
    tPowerDown();
    tFill();
    tPlay();
    tWipe();
    tHwReset();
    give_verdict();
  end

  // watchdog: the sequence needs about 11500 cycles
  initial begin
    repeat (40000) @(posedge clk);
    errCount++;
    give_verdict();
  end
endmodule // msq_ctrl_bench

// ===== sim/msq_link_host.sv
`timescale 1ns/1ps
module msq_link_host (
  // link pins towards the device
  output logic frameSync,
  output logic bitClk,
  output logic dataLine
);
  localparam int HALF_NS = 400;
  logic [23:0] frameBits;

  // idle link: strobe low, bit clock standing still
  initial begin
    frameSync = 1'h0;
    bitClk = 1'h0;
    dataLine = 1'h0;
  end

  // one frame of nBits; fewer than 24 makes a cut-short frame
  task automatic sendWord(input logic [7:0] idx, input logic [15:0] data, input int nBits);
    frameBits = {idx, data};
    frameSync = 1'h1;
    for (int i = 0; i < nBits; i++) begin
      dataLine = frameBits[23-i];
      #(HALF_NS);
      bitClk = 1'h1;
      #(HALF_NS);
      bitClk = 1'h0;
    end
    frameSync = 1'h0;
    // released data line must not look like a held bit
    dataLine = ~dataLine;
    #(2 * HALF_NS);
  endtask
endmodule // msq_link_host
